// *** bench/tb.sv ***
// self-checking bench for the inverter output option registers
`timescale 1ns/1ps
`default_nettype none

module tb;
  import inv_opt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0] sel = 4'hf; // byte enables of the bus request
  logic ce = 1'b1; // clock enable of the design
  logic [31:0] rdat;
  logic ack;
  logic [CHANNELS-1:0] run = '0, toe = '0, tom = '0, tme = '0;
  logic [CHANNELS-1:0] fire = '0, down = '0, level = '0;
  logic [CHANNELS-1:0] irq, cdn, tout, pins;
  logic ta_en, io_en, ta_rst, io_rst;
  logic out_chk = 1'b0; // strobe for an output comparison
  logic [31:0] rd_q[$]; // expected read data
  logic [15:0] out_q[$]; // expected {status, pins}
  int n_fail = 0, check_count = 0, cyc_cnt = 0, seed = 69224;
  logic [CHANNELS-1:0] r_tre, r_buf, r_lvl;

  // ----------------------------------------------------------------
  // clock, design and channel model
  // ----------------------------------------------------------------
  initial forever #12.5 mclk = ~mclk;

  inverter_output_option_regs i_dut (.mclk(mclk), .rst(rst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .channel_run_status(run), .channel_output_enable(toe),
    .combination_mode_bit(tom), .modulation_enable_bit(tme),
    .channel_interrupt_request(irq), .count_down(cdn),
    .timer_output(tout), .channel_output_pin(pins),
    .timer_array_clock_en(ta_en), .inverter_option_clock_en(io_en),
    .timer_array_reset(ta_rst), .inverter_option_reset(io_rst));

  timer_channel_model i_chan (.mclk(mclk), .rst(rst), .fire(fire),
    .down(down), .level(level), .irq(irq), .cnt_down(cdn), .tout(tout));

  // ----------------------------------------------------------------
  // reporting and comparison
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    $display("[FAIL] %0t %s", $time, msg);
    n_fail++;
  endtask

  task automatic test_done();
    if (rd_q.size() != 0 || out_q.size() != 0)
      fail("expected results never seen");
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // read data against the oldest note
  task automatic cmp_rd(input logic [31:0] got);
    check_count++;
    if (rd_q.size() == 0)
      fail("unexpected read");
    else if (got !== rd_q.pop_front())
      fail("read data differs");
  endtask

  // pins and clock control outputs against the oldest note
  task automatic cmp_out(input logic [15:0] got);
    check_count++;
    if (out_q.size() == 0)
      fail("unexpected output check");
    else if (got !== out_q.pop_front())
      fail("outputs differ");
  endtask

  // watcher: read data at the ack edge, outputs at the strobe edge
  always @(posedge mclk)
  begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
      cmp_rd(rdat);
    if (out_chk)
      cmp_out({io_rst, ta_rst, io_en, ta_en, pins});
  end

  // hang guard
  always @(posedge mclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 8000)
    begin
      fail("timeout");
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // one classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb_io(input logic w, input logic [IDX_W-1:0] idx,
                       input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    @(posedge mclk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20)
      fail("no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wb_wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    wb_io(1'b1, idx, d);
  endtask

  task automatic wb_rd(input logic [IDX_W-1:0] idx, input logic [15:0] e);
    rd_q.push_back({16'h0000, e});
    wb_io(1'b0, idx, 16'h0000);
  endtask

  // let levels settle, then note and strobe an output comparison
  task automatic expect_out(input logic [15:0] e);
    repeat (4) @(posedge mclk);
    out_q.push_back(e);
    out_chk <= 1'b1;
    @(posedge mclk);
    out_chk <= 1'b0;
  endtask

  // one request pulse from the channel model
  task automatic pulse(input logic [CHANNELS-1:0] m,
                       input logic [CHANNELS-1:0] d);
    fire <= m;
    down <= d;
    @(posedge mclk);
    fire <= '0;
    // one quiet edge so back-to-back pulses stay separate
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    expect_out({4'hc, 12'h000});
    wb_rd(IDX_PERIPH_EN, 16'h0000);
    wb_rd(IDX_TRI_MODE, 16'h0000);
    wb_rd(IDX_RT_EN, 16'h0000);
    wb_rd(IDX_RT_BUF, 16'h0000);
    // timer clock only: option block locked, pins follow plain level
    wb_wr(IDX_PERIPH_EN, 16'h0001);
    r_lvl = 12'($random(seed));
    level <= r_lvl;
    wb_wr(IDX_RT_BUF, 16'h0fff);
    wb_rd(IDX_RT_BUF, 16'h0000);
    expect_out({4'h9, r_lvl});
    wb_wr(IDX_PERIPH_EN, 16'h0003);
    wb_rd(IDX_PERIPH_EN, 16'h0003);
    wb_wr(IDX_TRI_MODE, 16'hffff);
    wb_rd(IDX_TRI_MODE, 16'h0fff);
    wb_wr(IDX_TRI_MODE, 16'h0000);
    // mode registers refuse writes while a channel runs
    run <= 12'h004;
    wb_wr(IDX_RT_EN, 16'h0fff);
    wb_rd(IDX_RT_EN, 16'h0000);
    wb_wr(IDX_TRI_MODE, 16'h0fff);
    wb_rd(IDX_TRI_MODE, 16'h0000);
    run <= '0;
    wb_rd(IDX_RT_BUF + 22'h1, 16'h0000);
    // random real-time settings with the combination gate off
    repeat (8)
    begin
      r_tre = 12'($random(seed));
      r_buf = 12'($random(seed));
      r_lvl = 12'($random(seed));
      tme <= 12'($random(seed));
      level <= r_lvl;
      wb_wr(IDX_RT_EN, {4'h0, r_tre});
      wb_wr(IDX_RT_BUF, {4'h0, r_buf});
      wb_rd(IDX_RT_EN, {4'h0, r_tre});
      repeat (4) @(posedge mclk);
      out_q.push_back({4'h3, (~r_tre & r_lvl) | (r_tre & ~tme & r_buf)
                       | (r_tre & tme & r_lvl & r_buf)});
      out_chk <= 1'b1;
      @(posedge mclk);
      out_chk <= 1'b0;
    end
    // combination latches, master/slave pair of channels 0 and 1
    wb_wr(IDX_RT_EN, 16'h0000);
    tme <= '0;
    toe <= '1;
    tom <= '1;
    level <= '0;
    pulse(12'h001, 12'h000);
    expect_out({4'h3, 12'h003});
    pulse(12'h002, 12'h000);
    expect_out({4'h3, 12'h001});
    wb_wr(IDX_TRI_MODE, 16'h0002);
    pulse(12'h002, 12'h002);
    pulse(12'h002, 12'h002);
    expect_out({4'h3, 12'h003});
    pulse(12'h001, 12'h000);
    expect_out({4'h3, 12'h003});
    pulse(12'h002, 12'h000);
    expect_out({4'h3, 12'h001});
    // triangle bits without combination mode change nothing
    wb_wr(IDX_TRI_MODE, 16'h0fff);
    tom <= '0;
    level <= '1;
    expect_out({4'h3, 12'hfff});
    // low byte enable only: upper byte of the buffer keeps its value
    sel <= 4'h1;
    wb_wr(IDX_RT_BUF, 16'h0fff);
    sel <= 4'hf;
    wb_rd(IDX_RT_BUF, {4'h0, r_buf[11:8], 8'hff});
    // clock enable low freezes the pins against a level change
    ce <= 1'b0;
    level <= '0;
    expect_out({4'h3, 12'hfff});
    ce <= 1'b1;
    expect_out({4'h3, 12'h000});
    // reset in mid-run clears every register again
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    expect_out({4'hc, 12'h000});
    wb_rd(IDX_PERIPH_EN, 16'h0000);
    wb_wr(IDX_PERIPH_EN, 16'h0003);
    wb_rd(IDX_TRI_MODE, 16'h0000);
    wb_wr(IDX_PERIPH_EN, 16'h0000);
    expect_out({4'hc, 12'h000});
    wb_rd(IDX_TRI_MODE, 16'h0000);
    repeat (2) @(posedge mclk);
    test_done();
  end
endmodule

`default_nettype wire

// *** bench/timer_channel_model.sv ***
// behavioural model of the timer array channels around the option block
`timescale 1ns/1ps
`default_nettype none

module timer_channel_model
  import inv_opt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [CHANNELS-1:0] fire, // one-cycle request per channel
  input wire logic [CHANNELS-1:0] down, // counting direction per channel
  input wire logic [CHANNELS-1:0] level, // plain timer output level
  output logic [CHANNELS-1:0] irq, // interrupt request pulses
  output logic [CHANNELS-1:0] cnt_down, // registered direction
  output logic [CHANNELS-1:0] tout // registered output level
);
  // requests leave as one-cycle pulses, levels follow one edge later
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq <= '0;
      cnt_down <= '0;
      tout <= '0;
    end
    else
    begin
      irq <= fire;
      cnt_down <= down;
      tout <= level;
    end
  end
endmodule

`default_nettype wire

// *** hw/channel_output_unit.sv ***
// set/reset output latch of one channel in combination operation
`timescale 1ns/1ps
`default_nettype none

module channel_output_unit
  import inv_opt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear, // option block held in reset
  input wire logic tri_mode, // triangle mode bit as programmed
  input wire logic gate, // combination output is active
  input wire logic master_irq, // interrupt request of the master channel
  input wire logic own_irq, // interrupt request of this channel
  input wire logic count_down, // this channel counts down
  output logic state_r // latched output level
);

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic applied_r; // mode in force, taken over at each set or reset
  logic set_ev; // output set request
  logic clr_ev; // output reset request

  // triangle: down-count request sets, up-count request resets
  assign set_ev = applied_r ? (own_irq & count_down) : master_irq;
  assign clr_ev = applied_r ? (own_irq & ~count_down) : own_irq;

  // ----------------------------------------------------------------
  // output latch, set wins when both arrive together
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || (ce && clear))
    begin
      state_r <= 1'b0;
      applied_r <= 1'b0;
    end
    else if (ce && gate && (set_ev || clr_ev))
    begin
      // new mode only takes hold at a set or reset edge
      state_r <= set_ev;
      applied_r <= tri_mode;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  set_on_event_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && !clear && gate && set_ev) |=> state_r)
    else $error("output not set on set event");

  reset_on_event_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && !clear && gate && clr_ev && !set_ev) |=> !state_r)
    else $error("output not reset on reset event");

endmodule

`default_nettype wire

// *** hw/inv_opt_pkg.sv ***
// shared constants and types for the inverter output option registers
`default_nettype none

package inv_opt_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CHANNELS = 12; // timer channels served
  localparam int OPT_W = 16; // width of each per-channel option register
  localparam int PER_W = 8; // width of the peripheral enable register
  localparam int ADR_W = 24; // wishbone byte address width
  localparam int IDX_W = 22; // register index width (byte address / 4)

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PERIPH_EN = 22'h0f00f2;
  localparam logic [IDX_W-1:0] IDX_TRI_MODE = 22'h0f01e8;
  localparam logic [IDX_W-1:0] IDX_RT_EN = 22'h0f01ea;
  localparam logic [IDX_W-1:0] IDX_RT_BUF = 22'h0f01ec;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PER_TIMER_BIT = 0; // timer array clock enable
  localparam int PER_INV_BIT = 1; // inverter option clock enable
  localparam logic [PER_W-1:0] PER_RESET = 8'h00;
  localparam logic [PER_W-1:0] PER_USED_MASK = 8'h03;
  localparam logic [OPT_W-1:0] OPT_RESET = 16'h0000;
  localparam logic [OPT_W-1:0] OPT_USED_MASK = 16'h0fff;

  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

`default_nettype wire

// *** hw/inverter_output_option_regs.sv ***
// clock gating and real-time/triangle output option registers, wishbone
// Notes on behaviour
// - clock off: writes ignored, reads give defaults
// - reset clears enable register, both clocks off
// - timer clock off: stopped, locked, in reset
// - option clock off: stopped, locked, in reset
// - triangle bit acts only in combination mode
// - new triangle mode applies at next set or reset event
// - mode 0: master request sets, own resets
// - mode 1: down request sets, up resets
// - real-time enable bit starts or stops output
// - real-time enabled, modulation off: pin follows buffer bit
// - real-time disabled: buffer has no effect
// - real-time enabled, modulation on: pin follows buffer and timer
// - reset clears triangle, enable, buffer registers
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module inverter_output_option_regs
  import inv_opt_pkg::*;
#(
  parameter int NCH = CHANNELS // number of channels
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce, // freezes all state while low
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer array side, same clock
  input wire logic [NCH-1:0] channel_run_status,
  input wire logic [NCH-1:0] channel_output_enable,
  input wire logic [NCH-1:0] combination_mode_bit,
  input wire logic [NCH-1:0] modulation_enable_bit,
  input wire logic [NCH-1:0] channel_interrupt_request,
  input wire logic [NCH-1:0] count_down,
  input wire logic [NCH-1:0] timer_output,
  // outputs
  output logic [NCH-1:0] channel_output_pin,
  output logic timer_array_clock_en,
  output logic inverter_option_clock_en,
  output logic timer_array_reset,
  output logic inverter_option_reset
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // merge a 16-bit write under byte enables
  function automatic logic [OPT_W-1:0] merge16(
    input logic [OPT_W-1:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [OPT_W-1:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res & OPT_USED_MASK;
  endfunction

  // true when the address selects the given register index
  function automatic logic hit(
    input logic [ADR_W-1:0] adr,
    input logic [IDX_W-1:0] idx
  );
    return adr[ADR_W-1:2] == idx;
  endfunction

  // ----------------------------------------------------------------
  // registers and wires
  // ----------------------------------------------------------------
  bus_state_t bus_r; // bus slave state
  logic [PER_W-1:0] per_r; // peripheral clock enable register
  logic [OPT_W-1:0] tri_r; // triangle wave mode
  logic [OPT_W-1:0] tre_r; // real-time output enable
  logic [OPT_W-1:0] tro_r; // real-time output buffer
  logic req; // request present
  logic wr_take; // write takes effect this edge
  logic timer_on; // timer array clock supplied
  logic inv_on; // option clock supplied
  logic running; // any channel counting
  logic [31:0] rd_nxt; // read data for the next answer
  logic [NCH-1:0] latch_q; // latched combination levels
  logic [NCH-1:0] gate; // combination output in force
  logic [NCH-1:0] comb; // level before real-time selection
  logic [NCH-1:0] pin_nxt; // next pin levels

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_take = ce && wb_ack_o && req && wb_we_i;
  assign timer_on = per_r[PER_TIMER_BIT];
  assign inv_on = per_r[PER_INV_BIT];
  assign running = |channel_run_status;

  // ----------------------------------------------------------------
  // bus handshake: ack one cycle after the request, for one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bus_r <= BUS_IDLE;
      wb_ack_o <= 1'b0;
    end
    else if (ce)
    begin
      case (bus_r)
        BUS_IDLE:
        begin
          // answer every request, mapped or not
          if (req)
          begin
            bus_r <= BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        BUS_ACK:
        begin
          // drop ack, back to idle at once, a held request is answered again
          bus_r <= BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
        default:
        begin
          bus_r <= BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux, option registers read zero while their clock is off
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (hit(wb_adr_i, IDX_PERIPH_EN))
      rd_nxt[PER_W-1:0] = per_r;
    else if (hit(wb_adr_i, IDX_TRI_MODE))
      rd_nxt[OPT_W-1:0] = inv_on ? tri_r : OPT_RESET;
    else if (hit(wb_adr_i, IDX_RT_EN))
      rd_nxt[OPT_W-1:0] = inv_on ? tre_r : OPT_RESET;
    else if (hit(wb_adr_i, IDX_RT_BUF))
      rd_nxt[OPT_W-1:0] = inv_on ? tro_r : OPT_RESET;
  end

  // read data is captured together with the rise of ack
  always_ff @(posedge mclk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (ce && bus_r == BUS_IDLE && req)
      wb_dat_o <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // peripheral clock enable register, always writable
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      per_r <= PER_RESET;
    else if (wr_take && wb_sel_i[0] && hit(wb_adr_i, IDX_PERIPH_EN))
      per_r <= wb_dat_i[PER_W-1:0] & PER_USED_MASK;
  end

  // ----------------------------------------------------------------
  // option registers: cleared and locked while the option clock is off
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tri_r <= OPT_RESET;
      tre_r <= OPT_RESET;
      tro_r <= OPT_RESET;
    end
    else if (ce && !inv_on)
    begin
      // option block in reset, writes ignored
      tri_r <= OPT_RESET;
      tre_r <= OPT_RESET;
      tro_r <= OPT_RESET;
    end
    else if (wr_take)
    begin
      // mode registers stay fixed while any channel runs
      if (hit(wb_adr_i, IDX_TRI_MODE) && !running)
        tri_r <= merge16(tri_r, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, IDX_RT_EN) && !running)
        tre_r <= merge16(tre_r, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, IDX_RT_BUF))
        tro_r <= merge16(tro_r, wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // clock gating and reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      timer_array_clock_en <= 1'b0;
      inverter_option_clock_en <= 1'b0;
      timer_array_reset <= 1'b1;
      inverter_option_reset <= 1'b1;
    end
    else if (ce)
    begin
      timer_array_clock_en <= timer_on;
      inverter_option_clock_en <= inv_on;
      timer_array_reset <= !timer_on;
      inverter_option_reset <= !inv_on;
    end
  end

  // ----------------------------------------------------------------
  // per-channel output latches; odd slaves follow the even master
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NCH; k++)
    begin : g_ch
      // combination only when enabled, and real-time and modulation agree
      assign gate[k] = channel_output_enable[k] && combination_mode_bit[k]
        && (tre_r[k] == modulation_enable_bit[k]);

      channel_output_unit u_unit (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .clear(!inv_on),
        .tri_mode(tri_r[k]),
        .gate(gate[k]),
        .master_irq(channel_interrupt_request[k - (k % 2)]),
        .own_irq(channel_interrupt_request[k]),
        .count_down(count_down[k]),
        .state_r(latch_q[k])
      );

      // latch level in combination mode, else the plain timer output
      assign comb[k] = gate[k] ? latch_q[k] : timer_output[k];

      // real-time: buffer alone, or buffer modulated by timer level
      assign pin_nxt[k] = !tre_r[k] ? comb[k]
        : (modulation_enable_bit[k] ? (comb[k] & tro_r[k])
        : tro_r[k]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // output pins, low while the timer array is held in reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      channel_output_pin <= '0;
    else if (ce)
      channel_output_pin <= timer_on ? pin_nxt : '0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ack_single_a: assert property (@(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_follows_req_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && req && !wb_ack_o && bus_r == BUS_IDLE) |=> wb_ack_o)
    else $error("request not answered next cycle");

  opt_cleared_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && !inv_on) |=> (tri_r == OPT_RESET && tre_r == OPT_RESET
      && tro_r == OPT_RESET))
    else $error("option registers not cleared with clock off");

  read_default_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && bus_r == BUS_IDLE && req && !wb_we_i && !inv_on
      && !hit(wb_adr_i, IDX_PERIPH_EN)) |=> wb_dat_o == 32'h0000_0000)
    else $error("read with clock off not default");

  timer_reset_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && !timer_on) |=> (timer_array_reset && channel_output_pin == '0))
    else $error("timer array not held in reset");

  rt_drive_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && timer_on) |=> ((channel_output_pin ^ $past(tro_r[NCH-1:0]))
      & $past(tre_r[NCH-1:0] & ~modulation_enable_bit)) == '0)
    else $error("pin does not follow real-time buffer");

  rt_no_effect_a: assert property (@(posedge mclk) disable iff (rst)
    (ce && timer_on) |=> ((channel_output_pin ^ $past(comb))
      & ~$past(tre_r[NCH-1:0])) == '0)
    else $error("real-time buffer leaks into disabled channel");

  run_lock_a: assert property (@(posedge mclk) disable iff (rst)
    (wr_take && running && inv_on && hit(wb_adr_i, IDX_TRI_MODE))
      |=> tri_r == $past(tri_r))
    else $error("triangle mode changed while running");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
    ((tri_r | tre_r | tro_r) & ~OPT_USED_MASK) == '0)
    else $error("reserved option bits set");

endmodule

`default_nettype wire
